// file: src/flash_suspend_command_gate.sv
// Opcode capture and admission gate for program/erase suspend of a serial flash.
// Assumes the SPI pins arrive asynchronously and the flash core runs on clk_sys.
`timescale 1ns/1ps

module flash_suspend_command_gate
   import flash_suspend_pkg::*;
#(
   parameter int lat_cycles = suspend_latency_cycles
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic spi_cs_n,
   input wire logic spi_sck,
   input wire logic spi_si,
   input wire logic op_start,
   input wire logic op_is_erase,
   input wire logic op_suspendable,
   input wire logic op_done,
   input wire logic op_resumed,
   output logic cmd_valid,
   output cmd_t cmd,
   output logic cmd_ignored,
   output logic suspend_start,
   output logic suspend_done,
   output flags_t flags
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic cs_s1_q, cs_s2_q, cs_s3_q;
   logic sck_s1_q, sck_s2_q, sck_s3_q;
   logic si_s1_q, si_s2_q;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         sck_s1_q <= 1'b0;
         sck_s2_q <= 1'b0;
         sck_s3_q <= 1'b0;
         si_s1_q <= 1'b0;
         si_s2_q <= 1'b0;
      end else begin
         cs_s1_q <= spi_cs_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         sck_s1_q <= spi_sck;
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
         si_s1_q <= spi_si;
         si_s2_q <= si_s1_q;
      end
   end

   logic bit_edge, cs_rise, byte_done;
   logic [7:0] opcode_w;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] shift_q, shift_d;

   assign bit_edge = sck_s2_q & ~sck_s3_q & ~cs_s2_q;
   assign cs_rise = cs_s2_q & ~cs_s3_q;
   assign opcode_w = {shift_q[6:0], si_s2_q};
   assign byte_done = bit_edge && (cnt_q == opcode_last_bit);

   // ------------------------------------------------------------
   // Opcode shifter
   // ------------------------------------------------------------
   always_comb begin
      cnt_d = cnt_q;
      shift_d = shift_q;
      if (cs_s2_q) begin
         cnt_d = bit_cnt_reset;
         shift_d = shift_reset;
      end else if (bit_edge) begin
         shift_d = opcode_w;
         if (cnt_q != bit_cnt_sat) begin
            cnt_d = cnt_q + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= bit_cnt_reset;
         shift_q <= shift_reset;
      end else begin
         cnt_q <= cnt_d;
         shift_q <= shift_d;
      end
   end

   // ------------------------------------------------------------
   // Admission tables
   // ------------------------------------------------------------
   function automatic logic is_suspend(input logic [7:0] op);
      return (op == op_suspend_a) || (op == op_suspend_b);
   endfunction

   function automatic logic in_always(input logic [7:0] op);
      case (op)
         op_rd_sr1, op_rd_sr2, op_rd_sr3, op_rd_sr_ind, op_act_int, op_terminate,
         op_rst_en, op_rst, op_id_a, op_id_b, op_id_c, op_dpd_exit: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic in_suspended(input logic [7:0] op);
      case (op)
         op_rd_a, op_rd_b, op_rd_c, op_rd_d, op_rd_e, op_rd_f, op_buf_rd, op_resume_a,
         op_resume_b, op_wr_en, op_wr_dis, op_vwr_en, op_lock_rd_a, op_lock_rd_b,
         op_otp_rd, op_sfdp, op_wrap, op_lowbat: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic in_erase_only(input logic [7:0] op);
      case (op)
         op_buf_wr, op_prog_s, op_prog_d, op_prog_q, op_buf_prog, op_seq_a,
         op_seq_b: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic needs_block_check(input logic [7:0] op);
      case (op)
         op_prog_s, op_prog_d, op_buf_prog, op_seq_a, op_seq_b: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   flags_t flags_q, flags_d;
   logic cur_erase_q, cur_erase_d;
   logic cur_suspend_summary_flag_ok_q, cur_suspend_summary_flag_ok_d;
   logic admit;
   logic flag_block;

   // Anything outside the lists is refused in a busy or suspended state, which covers
   // status writes, locks, erases, read-modify-write, OTP program and deep power-down.
   always_comb begin
      admit = 1'b0;
      if (flags_q.device_busy_flag) begin
         admit = in_always(opcode_w) || (is_suspend(opcode_w) && cur_suspend_summary_flag_ok_q);
      end else if (flags_q.program_suspended_flag) begin
         admit = in_always(opcode_w) || in_suspended(opcode_w);
      end else if (flags_q.erase_suspended_flag) begin
         admit = in_always(opcode_w) || in_suspended(opcode_w)
            || in_erase_only(opcode_w);
      end else begin
         admit = !is_suspend(opcode_w);
      end
   end

   assign flag_block = flags_q.erase_suspended_flag && !flags_q.program_suspended_flag
      && needs_block_check(opcode_w);

   // ------------------------------------------------------------
   // Command hand-off
   // ------------------------------------------------------------
   logic cmd_valid_q, cmd_valid_d;
   logic cmd_ignored_q, cmd_ignored_d;
   cmd_t cmd_q, cmd_d;

   always_comb begin
      cmd_valid_d = byte_done && admit;
      cmd_ignored_d = byte_done && !admit;
      cmd_d = cmd_q;
      if (byte_done && admit) begin
         cmd_d.code = opcode_w;
         cmd_d.block_check = flag_block;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cmd_valid_q <= 1'b0;
         cmd_ignored_q <= 1'b0;
         cmd_q <= cmd_reset;
      end else begin
         cmd_valid_q <= cmd_valid_d;
         cmd_ignored_q <= cmd_ignored_d;
         cmd_q <= cmd_d;
      end
   end

   // ------------------------------------------------------------
   // Suspend sequencer
   // ------------------------------------------------------------
   suspend_summary_flag_state_t state_q, state_d;
   logic [15:0] lat_q, lat_d;
   logic suspend_summary_flag_start_q, suspend_summary_flag_start_d;
   logic suspend_summary_flag_done_q, suspend_summary_flag_done_d;
   logic finish;

   always_comb begin
      state_d = state_q;
      lat_d = lat_q;
      suspend_summary_flag_start_d = 1'b0;
      finish = 1'b0;
      case (state_q)
         st_idle: begin
            if (byte_done && admit && is_suspend(opcode_w)) begin
               state_d = st_armed;
            end
         end
         st_armed: begin
            if (bit_edge) begin
               state_d = st_idle;
            end else if (cs_rise) begin
               if (cnt_q == opcode_bits && flags_q.device_busy_flag && cur_suspend_summary_flag_ok_q) begin
                  state_d = st_wait;
                  lat_d = 16'(lat_cycles - 1);
                  suspend_summary_flag_start_d = 1'b1;
               end else begin
                  state_d = st_idle;
               end
            end
         end
         st_wait: begin
            // A natural completion during the latency wins; nothing is left to suspend.
            if (op_done) begin
               state_d = st_idle;
            end else if (lat_q == lat_reset) begin
               state_d = st_idle;
               finish = 1'b1;
            end else begin
               lat_d = lat_q - 16'h0001;
            end
         end
         default: begin
            state_d = st_idle;
         end
      endcase
      suspend_summary_flag_done_d = finish;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= st_idle;
         lat_q <= lat_reset;
         suspend_summary_flag_start_q <= 1'b0;
         suspend_summary_flag_done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         lat_q <= lat_d;
         suspend_summary_flag_start_q <= suspend_summary_flag_start_d;
         suspend_summary_flag_done_q <= suspend_summary_flag_done_d;
      end
   end

   // ------------------------------------------------------------
   // Status flags
   // ------------------------------------------------------------
   always_comb begin
      flags_d = flags_q;
      cur_erase_d = cur_erase_q;
      cur_suspend_summary_flag_ok_d = cur_suspend_summary_flag_ok_q;
      if (op_start) begin
         flags_d.device_busy_flag = 1'b1;
         cur_erase_d = op_is_erase;
         cur_suspend_summary_flag_ok_d = op_suspendable;
      end
      if (op_done) begin
         flags_d.device_busy_flag = 1'b0;
      end
      if (op_resumed) begin
         // A suspended program resumes before a suspended erase.
         flags_d.device_busy_flag = 1'b1;
         cur_suspend_summary_flag_ok_d = 1'b1;
         if (flags_q.program_suspended_flag) begin
            flags_d.program_suspended_flag = 1'b0;
            cur_erase_d = 1'b0;
         end else begin
            flags_d.erase_suspended_flag = 1'b0;
            cur_erase_d = 1'b1;
         end
         flags_d.suspend_summary_flag = flags_d.program_suspended_flag
            | flags_d.erase_suspended_flag;
      end
      if (finish) begin
         flags_d.device_busy_flag = 1'b0;
         flags_d.suspend_summary_flag = 1'b1;
         if (cur_erase_q) begin
            flags_d.erase_suspended_flag = 1'b1;
         end else begin
            flags_d.program_suspended_flag = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         flags_q <= flags_reset;
         cur_erase_q <= 1'b0;
         cur_suspend_summary_flag_ok_q <= 1'b0;
      end else begin
         flags_q <= flags_d;
         cur_erase_q <= cur_erase_d;
         cur_suspend_summary_flag_ok_q <= cur_suspend_summary_flag_ok_d;
      end
   end

   assign cmd_valid = cmd_valid_q;
   assign cmd = cmd_q;
   assign cmd_ignored = cmd_ignored_q;
   assign suspend_start = suspend_summary_flag_start_q;
   assign suspend_done = suspend_summary_flag_done_q;
   assign flags = flags_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   localparam int lat_bound = lat_cycles + 1;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   property p_suspend_codes;
      byte_done && is_suspend(opcode_w) && flags_q.device_busy_flag && cur_suspend_summary_flag_ok_q
         && !op_done |=> state_q == st_armed;
   endproperty
   a_suspend_codes: assert property (p_suspend_codes)
      else $error("suspend opcode not armed");

   property p_extra_bits;
      state_q == st_armed && bit_edge |=> state_q == st_idle;
   endproperty
   a_extra_bits: assert property (p_extra_bits)
      else $error("suspend armed after extra bits");

   property p_msb_first;
      byte_done && admit |=> cmd_valid_q && cmd_q.code[7:1] == $past(shift_q[6:0]);
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("opcode bit order wrong");

   property p_start_on_release;
      $rose(state_q == st_wait) |-> $past(cs_rise) && $past(cnt_q) == opcode_bits;
   endproperty
   a_start_on_release: assert property (p_start_on_release)
      else $error("suspend started without release on byte");

   property p_drop;
      byte_done && !admit |=> cmd_ignored_q && !cmd_valid_q;
   endproperty
   a_drop: assert property (p_drop)
      else $error("refused opcode passed on");

   property p_busy_wren;
      byte_done && flags_q.device_busy_flag && opcode_w == op_wr_en |=> cmd_ignored_q;
   endproperty
   a_busy_wren: assert property (p_busy_wren)
      else $error("write enable passed while busy");

   property p_ps_bufrd;
      byte_done && !flags_q.device_busy_flag && flags_q.program_suspended_flag
         && opcode_w == op_buf_rd |=> cmd_valid_q;
   endproperty
   a_ps_bufrd: assert property (p_ps_bufrd)
      else $error("buffer read refused in program suspend");

   property p_es_bufwr;
      byte_done && !flags_q.device_busy_flag && !flags_q.program_suspended_flag
         && flags_q.erase_suspended_flag && opcode_w == op_buf_wr |=> cmd_valid_q;
   endproperty
   a_es_bufwr: assert property (p_es_bufwr)
      else $error("buffer write refused in erase suspend");

   property p_buf_prog;
      byte_done && opcode_w == op_buf_prog
         && (flags_q.device_busy_flag || flags_q.program_suspended_flag) |=> cmd_ignored_q;
   endproperty
   a_buf_prog: assert property (p_buf_prog)
      else $error("88h passed outside erase suspend");

   property p_sleep;
      byte_done && opcode_w == 8'hb9 && (flags_q.device_busy_flag
         || flags_q.program_suspended_flag || flags_q.erase_suspended_flag) |=> cmd_ignored_q;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("deep power-down passed while busy or suspended");

   property p_latency;
      suspend_summary_flag_start_q && !op_done |-> ##[1:lat_bound] (suspend_summary_flag_done_q || op_done);
   endproperty
   a_latency: assert property (p_latency)
      else $error("suspend not done within latency");

   property p_flags_done;
      suspend_summary_flag_done_q |-> !flags_q.device_busy_flag && flags_q.suspend_summary_flag
         && (flags_q.program_suspended_flag || flags_q.erase_suspended_flag);
   endproperty
   a_flags_done: assert property (p_flags_done)
      else $error("flags wrong after suspend");

   property p_nonsusp;
      state_q == st_armed && cs_rise && !cur_suspend_summary_flag_ok_q |=> state_q == st_idle;
   endproperty
   a_nonsusp: assert property (p_nonsusp)
      else $error("non-suspendable operation suspended");

   property p_block_check;
      cmd_valid_q && cmd_q.code == op_buf_prog |-> cmd_q.block_check;
   endproperty
   a_block_check: assert property (p_block_check)
      else $error("88h not flagged for block check");

   property p_rise_only;
      !bit_edge && !cs_s2_q |=> $stable(cnt_q);
   endproperty
   a_rise_only: assert property (p_rise_only)
      else $error("bit counted without rising edge");

   c_suspend_done: cover property (suspend_summary_flag_done_q);
   c_ignored: cover property (cmd_ignored_q);
   c_es_prog: cover property (cmd_valid_q && cmd_q.block_check);
   c_resume: cover property (op_resumed && flags_q.program_suspended_flag);

endmodule // flash_suspend_command_gate

// file: src/flash_suspend_pkg.sv
// Shared constants and types for the serial flash suspend command gate.
// Assumes a 200 MHz system clock and a core that owns the program and erase sequencing.
package flash_suspend_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int clk_period_ps = 5000;
   // The suspend latency is a longest time, so the cycle count rounds down, never below one.
   localparam int suspend_latency_time_ns = 1000;
   localparam int suspend_latency_raw = (suspend_latency_time_ns * 1000) / clk_period_ps;
   localparam int suspend_latency_cycles = (suspend_latency_raw < 1) ? 1 : suspend_latency_raw;

   // ------------------------------------------------------------
   // Frame bit counting
   // ------------------------------------------------------------
   localparam logic [3:0] bit_cnt_reset = 4'h0;
   localparam logic [3:0] opcode_last_bit = 4'h7;
   localparam logic [3:0] opcode_bits = 4'h8;
   localparam logic [3:0] bit_cnt_sat = 4'h9;
   localparam logic [7:0] shift_reset = 8'h00;
   localparam logic [15:0] lat_reset = 16'h0000;

   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] op_suspend_a = 8'h75, op_suspend_b = 8'hb0;
   localparam logic [7:0] op_resume_a = 8'h7a, op_resume_b = 8'hd0;
   localparam logic [7:0] op_rd_sr1 = 8'h05, op_rd_sr2 = 8'h35, op_rd_sr3 = 8'h15;
   localparam logic [7:0] op_rd_sr_ind = 8'h65, op_act_int = 8'h25, op_terminate = 8'hf0;
   localparam logic [7:0] op_rst_en = 8'h66, op_rst = 8'h99, op_dpd_exit = 8'hab;
   localparam logic [7:0] op_id_a = 8'h9f, op_id_b = 8'h90, op_id_c = 8'h94;
   localparam logic [7:0] op_rd_a = 8'h03, op_rd_b = 8'h0b, op_rd_c = 8'h3b;
   localparam logic [7:0] op_rd_d = 8'h6b, op_rd_e = 8'heb, op_rd_f = 8'he7;
   localparam logic [7:0] op_buf_rd = 8'hd4, op_wr_en = 8'h06, op_wr_dis = 8'h04;
   localparam logic [7:0] op_vwr_en = 8'h50, op_lock_rd_a = 8'h3c, op_lock_rd_b = 8'h3d;
   localparam logic [7:0] op_otp_rd = 8'h4b, op_sfdp = 8'h5a, op_wrap = 8'h77;
   localparam logic [7:0] op_lowbat = 8'hef;
   localparam logic [7:0] op_buf_wr = 8'h84, op_prog_s = 8'h02, op_prog_d = 8'ha2;
   localparam logic [7:0] op_prog_q = 8'h32, op_buf_prog = 8'h88;
   localparam logic [7:0] op_seq_a = 8'had, op_seq_b = 8'haf;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] code;
      logic block_check;
   } cmd_t;

   typedef struct packed {
      logic device_busy_flag;
      logic program_suspended_flag;
      logic erase_suspended_flag;
      logic suspend_summary_flag;
   } flags_t;

   localparam flags_t flags_reset = '0;
   localparam cmd_t cmd_reset = '0;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_armed = 2'b01,
      st_wait = 2'b11
   } suspend_summary_flag_state_t;

endpackage

// file: tb/flash_suspend_command_gate_test.sv
// Self-checking bench for the suspend command gate.
// Assumes the host model file and the gate with its package are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
   $display("ERROR %0t mismatch got %h exp %h", $time, a, b); end end

module flash_suspend_command_gate_test
   import flash_suspend_pkg::*;
;
   logic clk_sys, arst_n, spi_cs_n, spi_sck, spi_si;
   logic op_start, op_is_erase, op_suspendable, op_done, op_resumed;
   logic cmd_valid, cmd_ignored, suspend_start, suspend_done;
   cmd_t cmd;
   cmd_t last;
   flags_t flags;
   int err_total, compares, n_ok, n_ign, n_start, n_done, early;

   // ----------------------------------------
   // Instances
   // ----------------------------------------
   // A short latency keeps the run brief; expectations only count pulses.
   flash_suspend_command_gate #(.lat_cycles(4)) flash_suspend_command_gate_i (
      .clk_sys(clk_sys), .arst_n(arst_n), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
      .spi_si(spi_si), .op_start(op_start), .op_is_erase(op_is_erase),
      .op_suspendable(op_suspendable), .op_done(op_done), .op_resumed(op_resumed),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ignored(cmd_ignored),
      .suspend_start(suspend_start), .suspend_done(suspend_done), .flags(flags));

   spi_host_model spi_host_model_i (.spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // ----------------------------------------
   // Monitor
   // ----------------------------------------
   // Outputs are sampled mid-cycle, where they have settled after the launching edge.
   always @(negedge clk_sys) begin
      if (cmd_valid === 1'b1) begin
         n_ok++;
         last = cmd;
      end
      if (cmd_ignored === 1'b1) n_ign++;
      if (suspend_start === 1'b1) begin
         n_start++;
         if (spi_cs_n !== 1'b1) early++;
      end
      if (suspend_done === 1'b1) n_done++;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic test_done;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Core pulse {start, done, resumed, erase, suspendable}; levels stay held.
   task automatic core(input logic [4:0] v);
      @(posedge clk_sys);
      #1;
      {op_start, op_done, op_resumed, op_is_erase, op_suspendable} = v;
      @(posedge clk_sys);
      #1;
      {op_start, op_done, op_resumed} = 3'h0;
      repeat (3) @(posedge clk_sys);
   endtask

   // The settle time covers sync, answer and the shortened latency.
   task automatic send(input logic [7:0] code, input int extra);
      @(posedge clk_sys);
      #1;
      {n_ok, n_ign, n_start, n_done, early} = {5{32'sd0}};
      spi_host_model_i.frame(code, extra);
      repeat (20) @(posedge clk_sys);
   endtask

   task automatic chk(input logic [7:0] list[$], input logic ok, input logic bc);
      foreach (list[i]) begin
         send(list[i], 0);
         `CHK(n_ok == 1, ok)
         `CHK(n_ign == 1, !ok)
         if (ok) `CHK(last, cmd_t'{list[i], bc})
      end
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      #200000;
      err_total++;
      test_done;
   end

   initial begin
      arst_n = 1'b0;
      {op_start, op_done, op_resumed, op_is_erase, op_suspendable} = 5'h00;
      repeat (8) @(posedge clk_sys);
      #1 arst_n = 1'b1;
      repeat (4) @(posedge clk_sys);
      `CHK(flags, flags_reset)
      `CHK(cmd, cmd_reset)
      chk('{8'h75}, 1'b0, 1'b0);
      core(5'h11);
      `CHK(flags, 4'h8)
      chk('{8'h05, 8'h35, 8'h15, 8'h65, 8'h25, 8'hf0, 8'h66, 8'h99, 8'h9f, 8'h90,
            8'h94, 8'hab}, 1'b1, 1'b0);
      chk('{8'h03, 8'hd4, 8'h84, 8'h02, 8'h88, 8'h7a, 8'h06, 8'h50, 8'h3c, 8'h4b},
           1'b0, 1'b0);
      chk('{8'h01, 8'h31, 8'h11, 8'h71, 8'h6f, 8'h60, 8'hc7, 8'h58, 8'h0a, 8'h36,
            8'h39, 8'h7e, 8'h98, 8'h9b, 8'hb9, 8'h20, 8'hd8}, 1'b0, 1'b0);
      send(8'h75, -1);
      `CHK(n_start, 0)
      send(8'h75, 1);
      `CHK(n_start, 0)
      `CHK(flags, 4'h8)
      send(8'h75, 0);
      `CHK(n_ok, 1)
      `CHK(n_start, 1)
      `CHK(early, 0)
      `CHK(n_done, 1)
      `CHK(flags, 4'h5)
      $display("test busy and program suspend entry done");
      chk('{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'heb, 8'he7, 8'hd4, 8'h7a, 8'hd0, 8'h06,
            8'h04, 8'h50, 8'h3c, 8'h3d, 8'h4b, 8'h05, 8'h25}, 1'b1, 1'b0);
      chk('{8'h75, 8'hb0, 8'h84, 8'h02, 8'ha2, 8'h32, 8'h88, 8'had, 8'haf, 8'h20},
           1'b0, 1'b0);
      core(5'h05);
      `CHK(flags, 4'h8)
      core(5'h09);
      `CHK(flags, 4'h0)
      $display("test program suspend done");
      core(5'h13);
      send(8'hb0, 0);
      `CHK(n_start, 1)
      `CHK(flags, 4'h3)
      chk('{8'h84, 8'h32}, 1'b1, 1'b0);
      chk('{8'h02, 8'ha2, 8'h88, 8'had, 8'haf}, 1'b1, 1'b1);
      chk('{8'h75, 8'hb0, 8'h60, 8'hb9, 8'h71, 8'h58}, 1'b0, 1'b0);
      $display("test erase suspend done");
      core(5'h07);
      core(5'h0b);
      core(5'h10);
      send(8'h75, 0);
      `CHK(n_ign, 1)
      `CHK(n_start, 0)
      `CHK(flags, 4'h8)
      $display("test non-suspendable done");
      test_done;
   end
endmodule // flash_suspend_command_gate_test

// file: tb/spi_host_model.sv
// Behavioural host SPI controller that drives chip select, serial clock and serial input.
// Assumes the serial clock is idle low between frames and has an 80 ns period.
`timescale 1ns/1ps

module spi_host_model (
   output logic spi_cs_n,
   output logic spi_sck,
   output logic spi_si
);
   // ----------------------------------------
   // Idle lines
   // ----------------------------------------
   initial begin
      spi_cs_n = 1'b1;
      spi_sck = 1'b0;
      spi_si = 1'b0;
   end

   // ----------------------------------------
   // Frame
   // ----------------------------------------
   // Sends 8 + extra bits of an opcode-only frame; a ninth bit is a zero.
   // A short or long frame lets the bench test that odd lengths start no suspend.
   task automatic frame(input logic [7:0] code, input int extra);
      int i;
      spi_cs_n = 1'b0;
      #40;
      for (i = 7; i > -1 - extra; i--) begin
         spi_si = (i >= 0) ? code[i] : 1'b0;
         #40 spi_sck = 1'b1;
         #40 spi_sck = 1'b0;
      end
      #40 spi_cs_n = 1'b1;
      // The released line shows the inverse so no stale bit looks valid.
      spi_si = ~spi_si;
      #40;
   endtask
endmodule // spi_host_model
